// *** design/gpio_and_adc_monitor_regs.sv ***
// general pin, channel select and converter result registers
// Functional notes
// - bits 7:6 route pin to converter channel
// - bits 5:3 open-drain drive, reset released
// - bits 2:0 read live pin levels only
// - pins two and three only on large package
// - channel select low nibble, upper unused
// - codes 0-11 supplies, 11xx general pin
// - 12V input/output results, 55 mV steps
// - 12V sense result, 250 uV steps
// - 5V input 22 mV, or 15 mV steps
// - results at 10h-1Fh, read and write
// - general pin result, 10 mV steps
`timescale 1ns/10ps
module gpio_and_adc_monitor_regs #(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire gpio_adc_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire gpio_adc_pkg::conv_result_t conv_i,
	output logic [3:0] conv_channel_o,
	output logic [1:0] pin_route_o,
	input wire logic [2:0] pin_level_i,
	output logic [2:0] pin_out_o,
	output logic [2:0] pin_oe_o
);
	logic rst_meta;
	logic rst_n;
	logic [2:0] pin_sync_lvl;
	logic [1:0] pin_route;
	logic [2:0] pin_drive;
	logic [3:0] channel;
	logic [7:0] results [gpio_adc_pkg::RESULT_COUNT];
	logic [2:0] pin_mask;
	logic [2:0] level_view;
	logic [7:0] next_rdata;
	logic hit_result;
	logic [3:0] req_idx;
	logic [3:0] conv_idx;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < gpio_adc_pkg::PIN_COUNT; gi++) begin : g_sync
			pin_sync u_sync (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n),
				.async_i(pin_level_i[gi]),
				.sync_o(pin_sync_lvl[gi])
			);
		end
	endgenerate

	// small package has only the first pin bonded out
	assign pin_mask = LARGE_PACKAGE ? 3'h7 : 3'h1;
	assign level_view = pin_sync_lvl & pin_mask;
	assign hit_result = (req_i.addr >= gpio_adc_pkg::ADDR_RESULT_FIRST) &&
		(req_i.addr <= gpio_adc_pkg::ADDR_RESULT_LAST);
	assign req_idx = req_i.addr[3:0];
	// general pin channel covers all four 11xx codes
	assign conv_idx = (conv_i.channel[3:2] == 2'h3) ?
		gpio_adc_pkg::RESULT_GENERAL_PIN : conv_i.channel;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_route <= gpio_adc_pkg::SEL_RESET;
			pin_drive <= gpio_adc_pkg::DRIVE_RESET;
		end else if (req_i.write &&
			req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) begin
			pin_route <= req_i.wdata[gpio_adc_pkg::SEL_HI:gpio_adc_pkg::SEL_LO];
			pin_drive <= req_i.wdata[gpio_adc_pkg::DRIVE_LO +: 3];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			channel <= gpio_adc_pkg::CHAN_RESET;
		end else if (req_i.write &&
			req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL) begin
			channel <= req_i.wdata[3:0];
		end
	end

	// a conversion landing with a host write to the same slot wins,
	// since it is the fresher measurement
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < gpio_adc_pkg::RESULT_COUNT; i++) begin
				results[i] <= gpio_adc_pkg::RESET_BYTE;
			end
		end else begin
			if (req_i.write && hit_result) begin
				results[req_idx] <= req_i.wdata;
			end
			if (conv_i.valid) begin
				results[conv_idx] <= conv_i.code;
			end
		end
	end

	always_comb begin
		next_rdata = gpio_adc_pkg::RESET_BYTE;
		if (req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) begin
			next_rdata = {pin_route, pin_drive, level_view};
		end else if (req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL) begin
			next_rdata = {4'h0, channel};
		end else if (hit_result) begin
			next_rdata = results[req_idx];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= gpio_adc_pkg::RESET_BYTE;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.read;
			if (req_i.read) begin
				rdata_o <= next_rdata;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			conv_channel_o <= gpio_adc_pkg::CHAN_RESET;
			pin_route_o <= gpio_adc_pkg::SEL_RESET;
			pin_out_o <= 3'h0;
			pin_oe_o <= 3'h0;
		end else begin
			conv_channel_o <= channel;
			pin_route_o <= pin_route;
			pin_out_o <= 3'h0;
			// a 0 bit pulls low; a 1 releases the pin
			pin_oe_o <= ~pin_drive & pin_mask;
		end
	end

	property p_route_follows;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) |=>
		##1 pin_route_o == $past(req_i.wdata[7:6], 2);
	endproperty
	a_route_follows: assert property (p_route_follows)
		else $error("pin route not updated");

	property p_drive_pulls_low;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO &&
			req_i.wdata[3] == 1'b0) |=> ##1 pin_oe_o[0];
	endproperty
	a_drive_pulls_low: assert property (p_drive_pulls_low)
		else $error("pin one not pulled low");

	property p_small_pkg;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!LARGE_PACKAGE |-> pin_oe_o[2:1] == 2'h0;
	endproperty
	a_small_pkg: assert property (p_small_pkg)
		else $error("unbonded pin driven");

	property p_level_read;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.read && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) |=>
		rdata_o[2:0] == $past(level_view) && rvalid_o;
	endproperty
	a_level_read: assert property (p_level_read)
		else $error("pin levels misread");

	property p_chan_read;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.read && req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL) |=>
		rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(channel);
	endproperty
	a_chan_read: assert property (p_chan_read)
		else $error("channel select misread");

	property p_chan_out;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL &&
			!req_i.read) |=> ##1 conv_channel_o == $past(req_i.wdata[3:0], 2);
	endproperty
	a_chan_out: assert property (p_chan_out)
		else $error("converter channel stale");

	property p_result_store;
		@(posedge sys_clk_i) disable iff (!rst_n)
		conv_i.valid |=>
		results[$past(conv_idx)] == $past(conv_i.code);
	endproperty
	a_result_store: assert property (p_result_store)
		else $error("conversion result lost");

	property p_result_rw;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && hit_result &&
			!(conv_i.valid && conv_idx == req_idx)) |=>
		results[$past(req_idx)] == $past(req_i.wdata);
	endproperty
	a_result_rw: assert property (p_result_rw)
		else $error("result register write lost");

	property p_unmapped;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.read && req_i.addr > gpio_adc_pkg::ADDR_RESULT_LAST) |=>
		rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_route_hold;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) |=>
		$stable(pin_route) && $stable(pin_drive);
	endproperty
	a_route_hold: assert property (p_route_hold)
		else $error("pin register changed without write");

	property p_chan_hold;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL) |=>
		$stable(channel);
	endproperty
	a_chan_hold: assert property (p_chan_hold)
		else $error("channel changed without write");

	property p_chan_write;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_CHANNEL_SEL) |=>
		channel == $past(req_i.wdata[3:0]);
	endproperty
	a_chan_write: assert property (p_chan_write)
		else $error("channel write lost");

	property p_drive_releases;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.write && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO &&
			req_i.wdata[3]) |=> ##1 !pin_oe_o[0];
	endproperty
	a_drive_releases: assert property (p_drive_releases)
		else $error("pin one not released");

	property p_route_readback;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(req_i.read && req_i.addr == gpio_adc_pkg::ADDR_GENERAL_IO) |=>
		rdata_o[7:6] == $past(pin_route) &&
		rdata_o[5:3] == $past(pin_drive);
	endproperty
	a_route_readback: assert property (p_route_readback)
		else $error("pin register fields misread");

	property p_rvalid_after_read;
		@(posedge sys_clk_i) disable iff (!rst_n)
		req_i.read |=>
		rvalid_o;
	endproperty
	a_rvalid_after_read: assert property (p_rvalid_after_read)
		else $error("read not answered");

	property p_rvalid_only_read;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!req_i.read |=>
		!rvalid_o;
	endproperty
	a_rvalid_only_read: assert property (p_rvalid_only_read)
		else $error("answer without read");

	property p_rdata_hold;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!req_i.read |=>
		$stable(rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without read");

	property p_general_store;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(conv_i.valid && conv_i.channel[3:2] == 2'h3) |=>
		results[gpio_adc_pkg::RESULT_GENERAL_PIN] == $past(conv_i.code);
	endproperty
	a_general_store: assert property (p_general_store)
		else $error("general pin result misplaced");

	// pins pass two stages before the host may see them
	property p_level_sync;
		@(posedge sys_clk_i) disable iff (!rst_n)
		level_view ==
		($past(pin_level_i, 2) & pin_mask);
	endproperty
	a_level_sync: assert property (p_level_sync)
		else $error("pin level view out of step");
endmodule : gpio_and_adc_monitor_regs

// *** design/gpio_adc_pkg.sv ***
// shared constants and carrier types for the pin and converter registers
package gpio_adc_pkg;
	localparam logic [7:0] ADDR_GENERAL_IO = 8'h06;
	localparam logic [7:0] ADDR_CHANNEL_SEL = 8'h07;
	localparam logic [7:0] ADDR_RESULT_FIRST = 8'h10;
	localparam logic [7:0] ADDR_RESULT_LAST = 8'h1f;
	localparam int RESULT_COUNT = 16;
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int DRIVE_LO = 3;
	localparam int LEVEL_LO = 0;
	localparam int PIN_COUNT = 3;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [2:0] DRIVE_RESET = 3'h7;
	localparam logic [3:0] CHAN_RESET = 4'h0;
	localparam logic [3:0] CHAN_LAST_SUPPLY = 4'hb;
	localparam logic [3:0] CHAN_GENERAL_PIN = 4'hc;
	localparam logic [3:0] RESULT_GENERAL_PIN = 4'hc;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// result scaling in microvolts, per step and at full scale
	localparam int STEP_12V_UV = 55000;
	localparam int STEP_12V_SENSE_UV = 250;
	localparam int STEP_5V_UV = 22000;
	localparam int STEP_5V_AS_3V3_UV = 15000;
	localparam int STEP_GENERAL_PIN_UV = 10000;
	localparam int FULL_SCALE_12V_UV = 14025000;
	localparam int FULL_SCALE_12V_SENSE_UV = 63750;
	localparam int FULL_SCALE_5V_UV = 5610000;
	localparam int FULL_SCALE_GENERAL_PIN_UV = 2550000;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [3:0] channel;
		logic [7:0] code;
	} conv_result_t;
endpackage : gpio_adc_pkg

// *** design/pin_sync.sv ***
// two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module pin_sync (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	logic stage1;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= 1'b1;
			sync_o <= 1'b1;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule : pin_sync

// *** tb/host_model.sv ***
// register-side host model: one-cycle strobes, bounded wait for read answer
`timescale 1ns/10ps
module host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	output gpio_adc_pkg::reg_req_t req_o
);
	initial req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		req_o <= '0;
	endtask : wr

	// a missing answer comes back as unknown so the caller's compare fails
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		d = 'x;
		@(posedge clk_i);
		req_o <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		req_o <= '0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			if (rvalid_i === 1'b1) begin
				d = rdata_i;
				break;
			end
		end
	endtask : rd
endmodule : host_model

// *** tb/tb.sv ***
// self-checking bench for the pin, channel select and result registers
`timescale 1ns/10ps
module tb;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	gpio_adc_pkg::reg_req_t req;
	gpio_adc_pkg::conv_result_t conv = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic [3:0] chan;
	logic [1:0] route;
	logic [2:0] pin_oe;
	logic [2:0] pin_level;
	logic [2:0] pin_out;
	logic [7:0] rdata_small;
	logic [2:0] oe_small;
	logic [2:0] level_small;
	logic [7:0] v;
	int n_mismatch = 0;
	int cmp_count = 0;

	// open-drain pins with pull-ups: low only while pulled
	assign pin_level = ~pin_oe;
	assign level_small = ~oe_small;

	initial forever #2.5 sys_clk_i = ~sys_clk_i;

	gpio_and_adc_monitor_regs dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .conv_i(conv),
		.conv_channel_o(chan), .pin_route_o(route), .pin_level_i(pin_level),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe));
	host_model host (.clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.req_o(req));
	// small package copy sees the same host traffic
	gpio_and_adc_monitor_regs #(.LARGE_PACKAGE(1'b0)) dut_small (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req),
		.rdata_o(rdata_small), .rvalid_o(), .conv_i(conv),
		.conv_channel_o(), .pin_route_o(), .pin_level_i(level_small),
		.pin_out_o(), .pin_oe_o(oe_small));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask : rd_chk

	task automatic t_reset_values();
		rd_chk(8'h06, 8'h3f);
		chk("small 06", 8'h39, rdata_small);
		rd_chk(8'h07, 8'h00);
		chk("oe", 8'h00, {5'h0, pin_oe});
		chk("out", 8'h00, {5'h0, pin_out});
	endtask : t_reset_values

	task automatic t_pins(input logic [7:0] w, input logic [7:0] e,
		input logic [7:0] es);
		host.wr(8'h06, w);
		repeat (8) @(posedge sys_clk_i);
		#1;
		chk("route", {6'h0, w[7:6]}, {6'h0, route});
		chk("oe", {5'h0, ~w[5:3]}, {5'h0, pin_oe});
		rd_chk(8'h06, e);
		chk("small 06", es, rdata_small);
		chk("small oe", {7'h0, ~w[3]}, {5'h0, oe_small});
		chk("out", 8'h00, {5'h0, pin_out});
	endtask : t_pins

	task automatic t_channel();
		host.wr(8'h07, 8'hfa);
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk("chan", 8'h0a, {4'h0, chan});
		rd_chk(8'h07, 8'h0a);
	endtask : t_channel

	task automatic t_results();
		for (int i = 8'h10; i <= 8'h1f; i++) host.wr(8'(i), 8'(i) ^ 8'ha5);
		for (int i = 8'h10; i <= 8'h1f; i++) rd_chk(8'(i), 8'(i) ^ 8'ha5);
		host.wr(8'h08, 8'h55);
		rd_chk(8'h08, 8'h00);
		rd_chk(8'h20, 8'h00);
	endtask : t_results

	task automatic t_conv(input logic [3:0] ch, input logic [7:0] slot,
		input logic [7:0] cv);
		@(posedge sys_clk_i);
		conv <= '{valid: 1'b1, channel: ch, code: cv};
		@(posedge sys_clk_i);
		conv <= '0;
		rd_chk(slot, cv);
		rd_chk(8'h1f, 8'h1f ^ 8'ha5);
	endtask : t_conv

	task automatic t_mid_reset();
		resetn_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		t_reset_values();
		rd_chk(8'h1c, 8'h00);
	endtask : t_mid_reset

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		t_reset_values();
		t_pins(8'hc0, 8'hc0, 8'hc0);
		t_pins(8'h87, 8'h80, 8'h80);
		t_pins(8'h78, 8'h7f, 8'h79);
		t_pins(8'h28, 8'h2d, 8'h29);
		t_channel();
		t_results();
		t_conv(4'h0, 8'h10, 8'hff);
		t_conv(4'h1, 8'h11, 8'h3c);
		t_conv(4'h2, 8'h12, 8'h01);
		t_conv(4'h3, 8'h13, 8'h80);
		t_conv(4'hb, 8'h1b, 8'h42);
		t_conv(4'hc, 8'h1c, 8'h5a);
		t_conv(4'he, 8'h1c, 8'ha7);
		t_mid_reset();
		conclude();
	end
endmodule : tb
